// ==== hdl/bld_regs.svh ====
// Parameter addresses, reset values, ranges and timing of the backlight dimmer
`ifndef BLD_REGS_SVH
`define BLD_REGS_SVH

`define BLD_ADDR_W 10
`define BLD_DATA_W 16

`define BLD_ADDR_OP_BRIGHT 10'h024
`define BLD_ADDR_TIMEOUT 10'h2ea
`define BLD_ADDR_SB_BRIGHT 10'h2eb

`define BLD_RST_OP_BRIGHT 4'h6
`define BLD_RST_TIMEOUT 14'h0384
`define BLD_RST_SB_BRIGHT 4'h0

`define BLD_BRIGHT_MAX 4'h9
`define BLD_TIMEOUT_MIN 14'h003c
`define BLD_TIMEOUT_MAX 14'h270f

`define BLD_PWM_STEPS 4'h9

`define BLD_SECOND_NS 1000000000
`define BLD_CLK_PERIOD_NS 50
`define BLD_CYCLES_PER_SECOND (`BLD_SECOND_NS / `BLD_CLK_PERIOD_NS)

`endif

// ==== hdl/bld_pkg.sv ====
// Types shared by the backlight dimmer modules
package bld_pkg;

    typedef enum logic {
        BLD_OPERATE,
        BLD_STANDBY
    } bld_mode_e;

    typedef logic [3:0] bld_bright_t;
    typedef logic [13:0] bld_secs_t;

endpackage : bld_pkg

// ==== hdl/bld_tick_if.sv ====
// Carrier between the dimmer core and its one-second tick generator
interface bld_tick_if;
    logic clear;
    logic tick;

    modport gen (
        input clear,
        output tick
    );

    modport user (
        output clear,
        input tick
    );
endinterface : bld_tick_if

// ==== hdl/bld_tick.sv ====
// One-second tick generator, realigned whenever the core clears it
`include "bld_regs.svh"

module bld_tick
    import bld_pkg::*;
#(
    parameter int unsigned CYCLES_PER_SECOND = `BLD_CYCLES_PER_SECOND
) (
    input wire logic clk,
    input wire logic rst_n,
    bld_tick_if.gen tk
);
    localparam int unsigned CW = $clog2(CYCLES_PER_SECOND);

    if (CYCLES_PER_SECOND < 2) begin : g_chk
        $error("bld_tick: CYCLES_PER_SECOND must be at least 2");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } bld_tick_s;

    localparam logic [CW-1:0] LAST = CW'(CYCLES_PER_SECOND - 1);

    bld_tick_s st_reg;
    bld_tick_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (tk.clear) begin
            // A press restarts the second so the period is never short
            st_next.cnt = '0; // see R11
        end else if (st_reg.cnt == LAST) begin
            st_next.cnt = '0;
            st_next.tick = 1'b1; // see R11
        end else begin
            st_next.cnt = st_reg.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tk.tick = st_reg.tick;
endmodule : bld_tick

// ==== hdl/bld_top.sv ====
// Backlight idle dimmer: operation and standby brightness with an inactivity timer
//
// Behaviour
// R01: Ten brightness steps, codes 0 to 9
// R02: Code 0 dimmest, 9 brightest, monotonic
// R03: Two states, each with own brightness
// R04: Button press or restart selects operation
// R05: Inactivity timeout switches to standby brightness
// R06: Any of three buttons restarts full period
// R07: Equal settings give identical output levels
// R08: Operation brightness at 036, 0-9, default 6
// R09: Timeout at 746, 60-9999 s, default 900
// R10: Standby brightness at 747, 0-9, default 0
// R11: One-second tick counts; press/reset clear count
// R12: New timeout applies from next press/restart; a restart reloads the default 900 instead
`include "bld_regs.svh"

module bld_top
    import bld_pkg::*;
#(
    parameter int unsigned CYCLES_PER_SECOND = `BLD_CYCLES_PER_SECOND
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic [2:0] BUTTON,
    input wire logic [`BLD_ADDR_W-1:0] PARAM_ADDR,
    input wire logic [`BLD_DATA_W-1:0] PARAM_WDATA,
    input wire logic PARAM_WE,
    input wire logic PARAM_RE,
    output logic [`BLD_DATA_W-1:0] PARAM_RDATA,
    output logic [3:0] BACKLIGHT_LEVEL,
    output logic BACKLIGHT_PWM,
    output logic STANDBY_ACTIVE
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        bld_mode_e mode;
        bld_bright_t op_bright;
        bld_bright_t sb_bright;
        bld_secs_t timeout;
        bld_secs_t active_timeout;
        bld_secs_t sec_cnt;
        logic [3:0] pwm_cnt;
        bld_bright_t level;
        logic pwm;
        logic [`BLD_DATA_W-1:0] rdata;
    } bld_core_s;

    localparam bld_core_s RESET_STATE = '{
        mode: BLD_OPERATE,
        op_bright: `BLD_RST_OP_BRIGHT,
        sb_bright: `BLD_RST_SB_BRIGHT,
        timeout: `BLD_RST_TIMEOUT,
        active_timeout: `BLD_RST_TIMEOUT,
        sec_cnt: 14'h0000,
        pwm_cnt: 4'h0,
        level: `BLD_RST_OP_BRIGHT,
        pwm: 1'b0,
        rdata: 16'h0000
    };

    bld_core_s st_reg;
    bld_core_s st_next;

    bld_tick_if tk ();

    bld_tick #(
        .CYCLES_PER_SECOND(CYCLES_PER_SECOND)
    ) u_tick (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .tk(tk.gen)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic bright_ok(input logic [`BLD_DATA_W-1:0] v);
        bright_ok = (v <= {12'h000, `BLD_BRIGHT_MAX}); // see R01
    endfunction

    function automatic logic [`BLD_DATA_W-1:0] widen(input bld_secs_t v);
        widen = {2'b00, v};
    endfunction

    logic press;
    logic expired;

    // Any held button keeps the timer at zero, not only its first edge
    assign press = |BUTTON; // see R06
    assign tk.clear = press; // see R11
    assign expired = tk.tick && (st_reg.sec_cnt + 14'h0001 >= st_reg.active_timeout);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next = st_reg;

        // Parameter writes; out-of-range values are ignored, keeping the old one
        if (PARAM_WE) begin
            case (PARAM_ADDR)
                `BLD_ADDR_OP_BRIGHT: begin
                    if (bright_ok(PARAM_WDATA)) begin
                        st_next.op_bright = PARAM_WDATA[3:0]; // see R08
                    end
                end
                `BLD_ADDR_TIMEOUT: begin
                    if (PARAM_WDATA >= widen(`BLD_TIMEOUT_MIN)
                        && PARAM_WDATA <= widen(`BLD_TIMEOUT_MAX)) begin
                        st_next.timeout = PARAM_WDATA[13:0]; // see R09
                    end
                end
                `BLD_ADDR_SB_BRIGHT: begin
                    if (bright_ok(PARAM_WDATA)) begin
                        st_next.sb_bright = PARAM_WDATA[3:0]; // see R10
                    end
                end
                default: begin
                end
            endcase
        end

        if (PARAM_RE) begin
            case (PARAM_ADDR)
                `BLD_ADDR_OP_BRIGHT: st_next.rdata = {12'h000, st_reg.op_bright};
                `BLD_ADDR_TIMEOUT: st_next.rdata = widen(st_reg.timeout);
                `BLD_ADDR_SB_BRIGHT: st_next.rdata = {12'h000, st_reg.sb_bright};
                default: st_next.rdata = 16'h0000;
            endcase
        end

        // Inactivity timer and backlight state
        if (press) begin
            st_next.mode = BLD_OPERATE; // see R04
            st_next.sec_cnt = 14'h0000; // see R06
            // The running period only picks up a new timeout here
            st_next.active_timeout = st_reg.timeout; // see R12
        end else begin
            case (st_reg.mode)
                BLD_OPERATE: begin
                    if (expired) begin
                        st_next.mode = BLD_STANDBY; // see R05
                    end else if (tk.tick) begin
                        st_next.sec_cnt = st_reg.sec_cnt + 14'h0001; // see R11
                    end
                end
                BLD_STANDBY: begin
                end
                default: st_next.mode = BLD_OPERATE;
            endcase
        end

        // Level follows the state; equal settings give identical output
        st_next.level = (st_next.mode == BLD_STANDBY) ? st_next.sb_bright
                                                      : st_next.op_bright; // see R03 see R07

        // Duty of level/9: 0 is dark, 9 is fully on
        st_next.pwm_cnt = (st_reg.pwm_cnt == `BLD_PWM_STEPS - 4'h1) ? 4'h0
                                                                    : st_reg.pwm_cnt + 4'h1;
        st_next.pwm = (st_reg.pwm_cnt < st_reg.level); // see R02
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_reg <= RESET_STATE; // see R04
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign PARAM_RDATA = st_reg.rdata;
    assign BACKLIGHT_LEVEL = st_reg.level;
    assign BACKLIGHT_PWM = st_reg.pwm;
    assign STANDBY_ACTIVE = (st_reg.mode == BLD_STANDBY);

endmodule : bld_top

// ==== hdl/bld_tick_if_note_unused.sv ====
// Intentionally empty compile unit kept out; no logic here

// ==== tb/bld_top_sva.sv ====
// Port checker for the backlight idle dimmer
`include "bld_regs.svh"
module bld_top_sva (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic [2:0] BUTTON,
    input wire logic [`BLD_ADDR_W-1:0] PARAM_ADDR,
    input wire logic [`BLD_DATA_W-1:0] PARAM_WDATA,
    input wire logic PARAM_WE,
    input wire logic PARAM_RE,
    input wire logic [`BLD_DATA_W-1:0] PARAM_RDATA,
    input wire logic [3:0] BACKLIGHT_LEVEL,
    input wire logic BACKLIGHT_PWM,
    input wire logic STANDBY_ACTIVE
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    logic op_wr;
    logic mapped;
    logic [3:0] wr_val;
    assign op_wr = PARAM_WE && PARAM_ADDR == 10'h024 && PARAM_WDATA < 16'h000a;
    assign mapped = PARAM_ADDR inside {10'h024, 10'h2ea, 10'h2eb};
    always_ff @(posedge REF_CLK) begin
        if (op_wr) begin
            wr_val <= PARAM_WDATA[3:0];
        end
    end
    AST_LVL_RANGE: assert property (BACKLIGHT_LEVEL <= 4'h9) else $error("bad level");
    AST_PRESS: assert property (|BUTTON |=> !STANDBY_ACTIVE) else $error("press");
    AST_REST: assert property ($rose(RESETN) |-> !STANDBY_ACTIVE) else $error("restart");
    AST_ENTER: assert property ($rose(STANDBY_ACTIVE) |-> $past(BUTTON) == 3'h0)
        else $error("standby on press");
    AST_STAY: assert property (STANDBY_ACTIVE && BUTTON == 3'h0 |=> STANDBY_ACTIVE)
        else $error("left standby");
    AST_RD_UNMAP: assert property (PARAM_RE && !mapped |=> PARAM_RDATA == 16'h0000)
        else $error("unmapped read");
    AST_RD_HOLD: assert property (!PARAM_RE |=> $stable(PARAM_RDATA)) else $error("rdata");
    AST_OP_WR: assert property (op_wr && !STANDBY_ACTIVE
        |-> ##[1:2] (STANDBY_ACTIVE || BACKLIGHT_LEVEL == wr_val)) else $error("op level");
    COV_SB: cover property ($rose(STANDBY_ACTIVE));
    COV_WR: cover property (op_wr);
    COV_UNMAP: cover property (PARAM_RE && !mapped);
endmodule // bld_top_sva
////////////////////////////////////////////////////////////////////////////////
bind bld_top bld_top_sva u_bld_top_sva (.REF_CLK(REF_CLK), .RESETN(RESETN), .BUTTON(BUTTON),
    .PARAM_ADDR(PARAM_ADDR), .PARAM_WDATA(PARAM_WDATA), .PARAM_WE(PARAM_WE),
    .PARAM_RE(PARAM_RE), .PARAM_RDATA(PARAM_RDATA), .BACKLIGHT_LEVEL(BACKLIGHT_LEVEL),
    .BACKLIGHT_PWM(BACKLIGHT_PWM), .STANDBY_ACTIVE(STANDBY_ACTIVE));

// ==== tb/bld_panel.sv ====
// Front-panel buttons and backlight driver model
module bld_panel (
    input wire logic clk,
    input wire logic [2:0] press,
    input wire logic pwm,
    output logic [2:0] button,
    output logic [8:0] hist
);
    timeunit 1ns;
    timeprecision 100ps;
    initial button = 3'h0;
    // Nine samples span one PWM frame, so any window holds the duty
    always @(posedge clk) begin
        button <= press;
        hist <= {hist[7:0], pwm};
    end
endmodule // bld_panel

// ==== tb/bld_top_tb_top.sv ====
// Self-checking bench for the backlight idle dimmer
module bld_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic pwm;
    logic sb;
    logic [2:0] press = 3'h0;
    logic [2:0] btn;
    logic [9:0] addr = 10'h000;
    logic [15:0] wd = 16'h0000;
    logic [15:0] rd;
    logic [3:0] lvl;
    logic [8:0] hist;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    bld_top #(.CYCLES_PER_SECOND(4)) u_bld_top (.REF_CLK(clk), .RESETN(rst_n), .BUTTON(btn),
        .PARAM_ADDR(addr), .PARAM_WDATA(wd), .PARAM_WE(we), .PARAM_RE(re), .PARAM_RDATA(rd),
        .BACKLIGHT_LEVEL(lvl), .BACKLIGHT_PWM(pwm), .STANDBY_ACTIVE(sb));
    bld_panel u_bld_panel (.clk(clk), .press(press), .pwm(pwm), .button(btn), .hist(hist));
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk(rd, exp);
    endtask
    // Press for one cycle, then count cycles until standby, bounded
    task automatic press_wait(input logic [2:0] b);
        @(posedge clk);
        press <= b;
        @(posedge clk);
        press <= 3'h0;
        // The panel registers the press, so the core takes it one edge later
        @(posedge clk);
        #1 chk({15'h0000, sb}, 16'h0000);
        n = 0;
        while (sb !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(10'h024, 16'h0006);
        rd_chk(10'h2ea, 16'h0384);
        rd_chk(10'h2eb, 16'h0000);
        rd_chk(10'h100, 16'h0000);
        chk({11'h000, sb, lvl}, 16'h0006);
        $display("test reset done");
        wr(10'h024, 16'h000a);
        wr(10'h2ea, 16'h003b);
        wr(10'h2ea, 16'h2710);
        rd_chk(10'h024, 16'h0006);
        rd_chk(10'h2ea, 16'h0384);
        wr(10'h2ea, 16'h270f);
        rd_chk(10'h2ea, 16'h270f);
        wr(10'h2ea, 16'h003c);
        rd_chk(10'h2ea, 16'h003c);
        repeat (300) @(posedge clk);
        #1 chk({15'h0000, sb}, 16'h0000);
        $display("test ranges done");
        wr(10'h2eb, 16'h0002);
        wr(10'h024, 16'h0007);
        for (int b = 0; b < 3; b++) begin
            press_wait(3'h1 << b);
            chk(16'(n >= 238 && n <= 243), 16'h0001);
            chk({12'h000, lvl}, 16'h0002);
        end
        $display("test timeout done");
        for (int v = 0; v < 10; v++) begin
            wr(10'h2eb, 16'(v));
            repeat (12) @(posedge clk);
            #1 chk(16'($countones(hist)), 16'(v));
            chk({12'h000, lvl}, 16'(v));
        end
        wr(10'h2eb, 16'h000a);
        #1 chk({12'h000, lvl}, 16'h0009);
        $display("test levels done");
        wr(10'h024, 16'h0009);
        press_wait(3'h4);
        chk({11'h000, sb, lvl}, 16'h0019);
        $display("test equal done");
        // Restart from standby: operation state and default settings return
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({11'h000, sb, lvl}, 16'h0006);
        rd_chk(10'h2ea, 16'h0384);
        $display("test restart done");
        give_verdict();
    end
endmodule // bld_top_tb_top
